/* rtl/cpu_ops_pkg.sv */
// Shared constants, encodings and register map of the execution core.
package cpu_ops_pkg;

    // Data path widths.
    localparam int DATA_W = 8;
    localparam int INSTR_W = 12;
    localparam int PC_W = 11;
    localparam int FILE_AW = 5;
    localparam int FILE_DEPTH = 32;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // Instruction word fields.
    localparam int OP_HI = 11;
    localparam int OP_LO = 8;
    localparam int LIT_HI = 7;
    localparam int DEST_BIT = 5;
    localparam int FADDR_HI = 4;

    // Operation codes held in the top nibble of the word.
    localparam logic [3:0] OP_IDLE = 4'h0;
    localparam logic [3:0] OP_COPY_FILE_REG = 4'h1;
    localparam logic [3:0] OP_ROTATE_LEFT_CARRY = 4'h2;
    localparam logic [3:0] OP_LOAD_LITERAL_ACC = 4'h3;
    localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h4;
    localparam logic [3:0] OP_CONFIG_LOAD = 4'h5;
    localparam logic [3:0] OP_SLEEP = 4'h6;
    localparam logic [INSTR_W-1:0] IDLE_WORD = 12'h000;

    // Register byte addresses.
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_ACC = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_CONFIG = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_PC = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_STACK_HEAD = 8'h14;
    localparam logic [APB_AW-1:0] ADDR_WDT = 8'h18;

    // Control and status bit positions.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WDT_EN_BIT = 1;
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_CARRY_BIT = 1;
    localparam int ST_EXPIRY_N_BIT = 2;
    localparam int ST_PDOWN_N_BIT = 3;
    localparam int ST_PCWF_BIT = 4;
    localparam int ST_SLEEP_BIT = 5;
    localparam int STACK_HI_LO = 8;

    // Reset and clear values.
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] CONFIG_RST = 8'hff;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [DATA_W-1:0] WDT_CLEAR_VAL = 8'h00;
    localparam logic [DATA_W-1:0] WDT_MAX = 8'hff;
    localparam int PRESCALE_DIV_DEFAULT = 16;

    // Core execution state.
    typedef enum logic [0:0] {
        core_run,
        core_sleep
    } core_state_e;

endpackage

/* rtl/wdt_if.sv */
// Carrier between the core and its watchdog counter.
interface wdt_if;
    logic clear;
    logic enable;
    logic [cpu_ops_pkg::DATA_W-1:0] count;
    logic overflow;

    modport core (output clear, output enable, input count, input overflow);
    modport unit (input clear, input enable, output count, output overflow);
endinterface

/* rtl/wdt_unit.sv */
// Watchdog counter with its prescaler divider.
module wdt_unit #(
    parameter int PRESCALE_DIV = cpu_ops_pkg::PRESCALE_DIV_DEFAULT
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Link to the core.
    wdt_if.unit wdt
);
    localparam int PRE_W = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_DIV - 1);

    logic [PRE_W-1:0] pre_q;
    logic [cpu_ops_pkg::DATA_W-1:0] count_q;
    logic overflow_q;
    logic tick;

    // The prescaler yields a one-cycle enable for the counter.
    assign tick = wdt.enable && (pre_q == PRE_LAST);

    // Prescaler divider; a clear restarts it so the next timeout is full.
    always_ff @(posedge clock) begin
        if (!rstn || wdt.clear) begin
            pre_q <= '0;
        end else if (wdt.enable) begin
            pre_q <= tick ? '0 : pre_q + 1'b1;
        end
    end

    // Counter and overflow pulse; clear takes priority over a tick.
    always_ff @(posedge clock) begin
        if (!rstn || wdt.clear) begin
            count_q <= cpu_ops_pkg::WDT_CLEAR_VAL;
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= tick && (count_q == cpu_ops_pkg::WDT_MAX);
            if (tick) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign wdt.count = count_q;
    assign wdt.overflow = overflow_q;
endmodule

/* rtl/cpu_move_sleep_rotate_ops.sv */
// Execution core for move, literal, config, return, sleep and rotate.

// Operation
// [RULE1] Copy file register to accumulator or itself
// [RULE2] Copy updates zero flag from moved value
// [RULE3] Literal load to accumulator, flags untouched
// [RULE4] Config load copies accumulator, flags untouched
// [RULE5] Return loads literal, pc from stack head
// [RULE6] Return takes two instruction cycles
// [RULE7] Sleep clears watchdog counter and prescaler
// [RULE8] Sleep sets expiry, clears powerdown, keeps wake
// [RULE9] Sleep halts execution and stops oscillator
// [RULE10] Rotate left through carry, destination select
// [RULE11] Old carry enters bit 0, bit 7 out
// [RULE12] Taken skip replaces fetched word with idle
module cpu_move_sleep_rotate_ops #(
    parameter int PRESCALE_DIV = cpu_ops_pkg::PRESCALE_DIV_DEFAULT
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpu_ops_pkg::APB_AW-1:0] paddr,
    input wire logic [cpu_ops_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [cpu_ops_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction fetch.
    output logic [cpu_ops_pkg::PC_W-1:0] fetch_addr,
    input wire logic [cpu_ops_pkg::INSTR_W-1:0] instr_word,
    // Skip request from the rest of the core.
    input wire logic skip_req,
    // Wake pin and power control.
    input wire logic wake_pin,
    output logic osc_enable,
    output logic wdt_timeout
);
    // Pipeline state.
    logic [cpu_ops_pkg::PC_W-1:0] pc_q;
    logic [cpu_ops_pkg::INSTR_W-1:0] ir_q;
    cpu_ops_pkg::core_state_e state_q;

    // Architectural registers.
    logic [cpu_ops_pkg::DATA_W-1:0] file_q [cpu_ops_pkg::FILE_DEPTH];
    logic [cpu_ops_pkg::DATA_W-1:0] acc_q;
    logic [cpu_ops_pkg::DATA_W-1:0] config_q;
    logic [cpu_ops_pkg::PC_W-1:0] stack_head_q;
    logic zero_q;
    logic carry_q;
    logic expiry_n_q;
    logic pdown_n_q;
    logic pcwf_q;

    // Software control bits.
    logic run_q;
    logic wdt_en_q;

    // Bus slave state.
    logic [cpu_ops_pkg::APB_DW-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [cpu_ops_pkg::APB_DW-1:0] rdata;
    logic addr_hit;
    logic wr_fire;

    // Wake pin synchroniser.
    logic wake_s1_q;
    logic wake_s2_q;
    logic wake_s3_q;
    logic wake_lvl_q;
    logic pin_change;

    // Decode.
    logic [3:0] op;
    logic dest_file;
    logic [cpu_ops_pkg::FILE_AW-1:0] faddr;
    logic [cpu_ops_pkg::DATA_W-1:0] literal;
    logic [cpu_ops_pkg::DATA_W-1:0] src;
    logic [cpu_ops_pkg::DATA_W-1:0] rot_res;
    logic exec_en;
    logic do_sleep;
    logic wake_now;

    wdt_if wdt ();

    wdt_unit #(
        .PRESCALE_DIV(PRESCALE_DIV)
    ) u_wdt (
        .clock(clock),
        .rstn(rstn),
        .wdt(wdt)
    );

    // Field extraction from the word in the execute stage.
    assign op = ir_q[cpu_ops_pkg::OP_HI:cpu_ops_pkg::OP_LO];
    assign dest_file = ir_q[cpu_ops_pkg::DEST_BIT];
    assign faddr = ir_q[cpu_ops_pkg::FADDR_HI:0];
    assign literal = ir_q[cpu_ops_pkg::LIT_HI:0];
    assign src = file_q[faddr];
    assign rot_res = {src[cpu_ops_pkg::DATA_W-2:0], carry_q}; // RULE11
    assign exec_en = run_q && (state_q == cpu_ops_pkg::core_run);
    assign do_sleep = exec_en && (op == cpu_ops_pkg::OP_SLEEP);

    // Sleep ends on a settled pin change or on a watchdog overflow.
    assign wake_now = (state_q == cpu_ops_pkg::core_sleep)
                      && (pin_change || wdt.overflow);

    // Three stages; only the last two are compared, so the first flop
    // is free to go metastable without reaching any logic.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // A change counts once the two later stages agree.
    assign pin_change = (wake_s2_q == wake_s3_q)
                        && (wake_s2_q != wake_lvl_q);

    // Settled level of the wake pin.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wake_lvl_q <= 1'b0;
        end else if (pin_change) begin
            wake_lvl_q <= wake_s2_q;
        end
    end

    // Fetch and pipeline; a flush replaces the fetched word with idle.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pc_q <= cpu_ops_pkg::PC_RST;
            ir_q <= cpu_ops_pkg::IDLE_WORD;
        end else if (exec_en) begin
            if (op == cpu_ops_pkg::OP_RETURN_WITH_LITERAL) begin
                pc_q <= stack_head_q; // RULE5
                ir_q <= cpu_ops_pkg::IDLE_WORD; // RULE6
            end else if (skip_req) begin
                pc_q <= pc_q + 1'b1;
                ir_q <= cpu_ops_pkg::IDLE_WORD; // RULE12
            end else begin
                pc_q <= pc_q + 1'b1;
                ir_q <= instr_word;
            end
        end
    end

    assign fetch_addr = pc_q;

    // Accumulator writes; literal and return leave flags alone.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_q <= cpu_ops_pkg::ACC_RST;
        end else if (exec_en) begin
            case (op)
                cpu_ops_pkg::OP_COPY_FILE_REG: begin
                    if (!dest_file) begin
                        acc_q <= src; // RULE1
                    end
                end
                cpu_ops_pkg::OP_ROTATE_LEFT_CARRY: begin
                    if (!dest_file) begin
                        acc_q <= rot_res; // RULE10
                    end
                end
                cpu_ops_pkg::OP_LOAD_LITERAL_ACC: begin
                    acc_q <= literal; // RULE3
                end
                cpu_ops_pkg::OP_RETURN_WITH_LITERAL: begin
                    acc_q <= literal; // RULE5
                end
                default: begin
                    acc_q <= acc_q;
                end
            endcase
        end
    end

    // File register write back; data storage needs no reset.
    always_ff @(posedge clock) begin
        if (exec_en && dest_file) begin
            if (op == cpu_ops_pkg::OP_COPY_FILE_REG) begin
                file_q[faddr] <= src; // RULE1
            end else if (op == cpu_ops_pkg::OP_ROTATE_LEFT_CARRY) begin
                file_q[faddr] <= rot_res; // RULE10
            end
        end
    end

    // Zero flag follows the moved value, even when written to itself.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            zero_q <= 1'b0;
        end else if (exec_en && (op == cpu_ops_pkg::OP_COPY_FILE_REG)) begin
            zero_q <= (src == '0); // RULE2
        end
    end

    // Carry takes the bit shifted out of the top.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            carry_q <= 1'b0;
        end else if (exec_en
                     && (op == cpu_ops_pkg::OP_ROTATE_LEFT_CARRY)) begin
            carry_q <= src[cpu_ops_pkg::DATA_W-1]; // RULE11
        end
    end

    // Configuration register takes the accumulator as it stands.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            config_q <= cpu_ops_pkg::CONFIG_RST;
        end else if (exec_en && (op == cpu_ops_pkg::OP_CONFIG_LOAD)) begin
            config_q <= acc_q; // RULE4
        end
    end

    // Execution state; sleep freezes the pipeline until a wake.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= cpu_ops_pkg::core_run;
        end else begin
            case (state_q)
                cpu_ops_pkg::core_run: begin
                    if (do_sleep) begin
                        state_q <= cpu_ops_pkg::core_sleep; // RULE9
                    end
                end
                cpu_ops_pkg::core_sleep: begin
                    if (wake_now) begin
                        state_q <= cpu_ops_pkg::core_run;
                    end
                end
                default: begin
                    state_q <= cpu_ops_pkg::core_run;
                end
            endcase
        end
    end

    // Oscillator runs only while the core is awake.
    assign osc_enable = (state_q == cpu_ops_pkg::core_run); // RULE9

    // Power flags; the sleep clear beats an overflow in the same cycle,
    // since the watchdog is restarted then and that overflow is stale.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            expiry_n_q <= 1'b1;
            pdown_n_q <= 1'b1;
        end else if (do_sleep) begin
            expiry_n_q <= 1'b1; // RULE8
            pdown_n_q <= 1'b0; // RULE8
        end else if (wdt.overflow) begin
            expiry_n_q <= 1'b0;
        end
    end

    // Pin-change wake flag: sleep leaves it alone, a set beats the clear.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pcwf_q <= 1'b0;
        end else if ((state_q == cpu_ops_pkg::core_sleep) && pin_change) begin
            pcwf_q <= 1'b1;
        end else if (wr_fire && (paddr == cpu_ops_pkg::ADDR_STATUS)
                     && pstrb[0] && pwdata[cpu_ops_pkg::ST_PCWF_BIT]) begin
            pcwf_q <= 1'b0;
        end
    end

    // Watchdog link; sleep restarts counter and prescaler together.
    assign wdt.clear = do_sleep; // RULE7
    assign wdt.enable = wdt_en_q;
    assign wdt_timeout = wdt.overflow;

    // Address decode and read data.
    always_comb begin
        rdata = '0;
        addr_hit = 1'b1;
        case (paddr)
            cpu_ops_pkg::ADDR_CTRL: begin
                rdata[cpu_ops_pkg::CTRL_RUN_BIT] = run_q;
                rdata[cpu_ops_pkg::CTRL_WDT_EN_BIT] = wdt_en_q;
            end
            cpu_ops_pkg::ADDR_STATUS: begin
                rdata[cpu_ops_pkg::ST_ZERO_BIT] = zero_q;
                rdata[cpu_ops_pkg::ST_CARRY_BIT] = carry_q;
                rdata[cpu_ops_pkg::ST_EXPIRY_N_BIT] = expiry_n_q;
                rdata[cpu_ops_pkg::ST_PDOWN_N_BIT] = pdown_n_q;
                rdata[cpu_ops_pkg::ST_PCWF_BIT] = pcwf_q;
                rdata[cpu_ops_pkg::ST_SLEEP_BIT] =
                    (state_q == cpu_ops_pkg::core_sleep);
            end
            cpu_ops_pkg::ADDR_ACC: rdata[cpu_ops_pkg::DATA_W-1:0] = acc_q;
            cpu_ops_pkg::ADDR_CONFIG: begin
                rdata[cpu_ops_pkg::DATA_W-1:0] = config_q;
            end
            cpu_ops_pkg::ADDR_PC: rdata[cpu_ops_pkg::PC_W-1:0] = pc_q;
            cpu_ops_pkg::ADDR_STACK_HEAD: begin
                rdata[cpu_ops_pkg::PC_W-1:0] = stack_head_q;
            end
            cpu_ops_pkg::ADDR_WDT: begin
                rdata[cpu_ops_pkg::DATA_W-1:0] = wdt.count;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // Answer is prepared in setup so read data comes from a flop; this
    // costs nothing since pready rises in the first access cycle.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pready_q <= 1'b1;
            prdata_q <= pwrite ? '0 : rdata;
            pslverr_q <= !addr_hit;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0; // Error stands only with its answer.
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;

    // Control register.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            run_q <= 1'b0;
            wdt_en_q <= 1'b0;
        end else if (wr_fire && (paddr == cpu_ops_pkg::ADDR_CTRL)
                     && pstrb[0]) begin
            run_q <= pwdata[cpu_ops_pkg::CTRL_RUN_BIT];
            wdt_en_q <= pwdata[cpu_ops_pkg::CTRL_WDT_EN_BIT];
        end
    end

    // Stack head holds the return address, written by byte lanes.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stack_head_q <= cpu_ops_pkg::PC_RST;
        end else if (wr_fire && (paddr == cpu_ops_pkg::ADDR_STACK_HEAD)) begin
            if (pstrb[0]) begin
                stack_head_q[cpu_ops_pkg::STACK_HI_LO-1:0] <=
                    pwdata[cpu_ops_pkg::STACK_HI_LO-1:0];
            end
            if (pstrb[1]) begin
                stack_head_q[cpu_ops_pkg::PC_W-1:cpu_ops_pkg::STACK_HI_LO] <=
                    pwdata[cpu_ops_pkg::PC_W-1:cpu_ops_pkg::STACK_HI_LO];
            end
        end
    end
endmodule

/* verification/cpu_ops_chk.sv */
// Port-level checker for the move, sleep and rotate execution core.
module cpu_ops_chk #(
    parameter int PRESCALE_DIV = cpu_ops_pkg::PRESCALE_DIV_DEFAULT
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpu_ops_pkg::APB_AW-1:0] paddr,
    input wire logic [cpu_ops_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [cpu_ops_pkg::APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Fetch, skip and power.
    input wire logic [cpu_ops_pkg::PC_W-1:0] fetch_addr,
    input wire logic [cpu_ops_pkg::INSTR_W-1:0] instr_word,
    input wire logic skip_req,
    input wire logic wake_pin,
    input wire logic osc_enable,
    input wire logic wdt_timeout
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // A fetched word counts only if the counter moved on past it unflushed.
    sequence taken_op(logic [3:0] op);
        osc_enable && !skip_req && instr_word[11:8] == op
            ##1 fetch_addr == $past(fetch_addr) + 11'h1;
    endsequence

    // The bus has no wait states, so the answer is never late.
    a_ready_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no answer in the first access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("answer outside an access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without an answer");
    a_write_reads_zero: assert property (pready && pwrite |-> prdata == 0)
        else $error("read data not zero on a write");
    a_sleep_stops_osc: assert property (
        taken_op(cpu_ops_pkg::OP_SLEEP) |=> !osc_enable)
        else $error("oscillator still running after sleep");
    a_sleep_frozen: assert property (
        !osc_enable ##1 !osc_enable |-> $stable(fetch_addr))
        else $error("fetch moved while asleep");
    a_return_jumps: assert property (
        taken_op(cpu_ops_pkg::OP_RETURN_WITH_LITERAL)
            |=> fetch_addr != $past(fetch_addr) + 11'h1)
        else $error("return did not redirect the fetch");
    a_timeout_pulse: assert property (wdt_timeout |=> !wdt_timeout)
        else $error("timeout pulse longer than one cycle");
    a_reset_state: assert property ($rose(rstn) |->
        osc_enable && fetch_addr == 11'h0 && !pready)
        else $error("outputs not at reset values");

    // Main scenarios reached by the bench.
    c_refused: cover property (pslverr);
    c_asleep: cover property ($fell(osc_enable));
    c_woken: cover property ($rose(osc_enable));
    c_skip: cover property (skip_req && osc_enable);
endmodule

bind cpu_move_sleep_rotate_ops cpu_ops_chk #(
    .PRESCALE_DIV(PRESCALE_DIV)
) chk_i (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .instr_word(instr_word),
    .skip_req(skip_req), .wake_pin(wake_pin), .osc_enable(osc_enable),
    .wdt_timeout(wdt_timeout)
);

/* verification/cpu_move_sleep_rotate_ops_test.sv */
// Self-checking bench for the move, sleep and rotate execution core.
module cpu_move_sleep_rotate_ops_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [10:0] fetch_addr;
    logic [11:0] instr_word;
    logic skip_req = 1'b0;
    logic skip_arm = 1'b0;
    logic wake_pin = 1'b0;
    logic osc_enable;
    logic wdt_timeout;
    logic [11:0] prog [64];
    logic [31:0] rst_val [7] = '{32'h0, 32'h0c, 32'h0, 32'hff, 0, 0, 0};
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int check_count = 0;

    // The program store answers in the same cycle as the fetch address.
    assign instr_word = prog[fetch_addr[5:0]];

    // Flush raised while the word after address 2 is being fetched.
    always @(posedge clock) skip_req <= skip_arm && fetch_addr == 11'h2;

    // A small prescaler keeps watchdog wraps within a short run.
    cpu_move_sleep_rotate_ops #(.PRESCALE_DIV(2)) dut (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetch_addr(fetch_addr), .instr_word(instr_word),
        .skip_req(skip_req), .wake_pin(wake_pin),
        .osc_enable(osc_enable), .wdt_timeout(wdt_timeout)
    );

    // Forty megahertz clock.
    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h not %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        fail_count++;
        $display("unexpected at %0t: %s timed out", $time, what);
        end_sim();
    endtask

    // One bus transfer; the answer is waited for, never assumed.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) hang("bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll the sleeping bit, with a bound on the number of reads.
    task automatic wait_sleep();
        int k;
        k = 0;
        do begin
            apb(cpu_ops_pkg::ADDR_STATUS, 1'b0, 32'h0);
            k++;
        end while (rd[5] !== 1'b1 && k < 40);
        if (rd[5] !== 1'b1) hang("sleep entry");
    endtask

    initial begin
        int k;
        for (int i = 0; i < 64; i++) prog[i] = cpu_ops_pkg::IDLE_WORD;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        // Reset values, a refused address and a read-only write.
        for (int i = 0; i < 7; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0);
            chk(rd, rst_val[i]);
        end
        apb(8'h1c, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(cpu_ops_pkg::ADDR_ACC, 1'b1, 32'hff);
        apb(cpu_ops_pkg::ADDR_ACC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        // Literal, config, return then sleep, with the watchdog on.
        prog[0] = 12'h35a;
        prog[1] = 12'h500;
        prog[2] = 12'h4a5;
        prog[3] = 12'h311;
        prog[60] = 12'h600;
        apb(cpu_ops_pkg::ADDR_STACK_HEAD, 1'b1, 32'h20);
        apb(cpu_ops_pkg::ADDR_CTRL, 1'b1, 32'h3);
        wait_sleep();
        chk(rd, 32'h24);
        apb(cpu_ops_pkg::ADDR_WDT, 1'b0, 32'h0);
        chk({31'h0, rd < 32'h8}, 32'h1);
        chk({31'h0, osc_enable}, 32'h0);
        apb(cpu_ops_pkg::ADDR_ACC, 1'b0, 32'h0);
        chk(rd, 32'ha5);
        apb(cpu_ops_pkg::ADDR_CONFIG, 1'b0, 32'h0);
        chk(rd, 32'h5a);
        // Stop the core so that waking does not rerun the program.
        apb(cpu_ops_pkg::ADDR_CTRL, 1'b1, 32'h0);
        wake_pin <= 1'b1;
        k = 0;
        while (osc_enable !== 1'b1 && k < 20) begin
            @(posedge clock);
            k++;
        end
        if (osc_enable !== 1'b1) hang("wake");
        // Waking does not restore the powerdown flag; only reset does.
        apb(cpu_ops_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h14);
        apb(cpu_ops_pkg::ADDR_STATUS, 1'b1, 32'h10);
        apb(cpu_ops_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h04);
        $display("test sleep done");
        // After a fresh reset: copy and rotate to file, then a skip.
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 64; i++) prog[i] = cpu_ops_pkg::IDLE_WORD;
        prog[0] = 12'h377;
        prog[1] = 12'h123;
        prog[2] = 12'h224;
        prog[3] = 12'h333;
        prog[4] = 12'h500;
        prog[5] = 12'h600;
        skip_arm <= 1'b1;
        apb(cpu_ops_pkg::ADDR_CTRL, 1'b1, 32'h1);
        wait_sleep();
        apb(cpu_ops_pkg::ADDR_ACC, 1'b0, 32'h0);
        chk(rd, 32'h77);
        apb(cpu_ops_pkg::ADDR_CONFIG, 1'b0, 32'h0);
        chk(rd, 32'h77);
        $display("test skip done");
        // Watchdog alone: its wrap must end the sleep and mark expiry.
        apb(cpu_ops_pkg::ADDR_CTRL, 1'b1, 32'h2);
        k = 0;
        while (wdt_timeout !== 1'b1 && k < 600) begin
            @(posedge clock);
            k++;
        end
        if (wdt_timeout !== 1'b1) hang("watchdog wrap");
        apb(cpu_ops_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk({30'h0, rd[5], rd[2]}, 32'h0);
        $display("test watchdog done");
        end_sim();
    end
endmodule
